// ---- rtl/acis_clk_div.v ----
// converter clock enable divider: one pulse every 2**sel system clocks
`timescale 1ns/1ps
module acis_clk_div (
  // clock and reset
  input  wire       clk_sys_in,
  input  wire       nrst_in,
  // control
  input  wire       restart_in,
  input  wire [2:0] div_sel_in,
  // enable pulse
  output wire       tick_out
);

  reg  [6:0] cnt_r;
  wire [6:0] mask;

  // low div_sel_in bits set: the count wraps through them every 2**sel cycles
  assign mask     = (7'h7F >> (3'h7 - div_sel_in));
  assign tick_out = ((cnt_r & mask) == mask);

  // restart aligns the first converter period to the launch
  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_r <= 7'h00;
    end else if (restart_in) begin
      cnt_r <= 7'h00;
    end else begin
      cnt_r <= cnt_r + 7'h01;
    end
  end

endmodule // acis_clk_div

// ---- rtl/acis_defs.vh ----
// constants for the converter control and input select block
`ifndef ACIS_DEFS_VH
`define ACIS_DEFS_VH

// ****************************************************************
// register byte addresses
// ****************************************************************
`define ACIS_ADDR_CTRL0      8'h00
`define ACIS_ADDR_CTRL1      8'h04
`define ACIS_ADDR_RES_LO     8'h08
`define ACIS_ADDR_RES_HI     8'h0C
`define ACIS_ADDR_MODE       8'h10

// ****************************************************************
// field positions, control register 0
// ****************************************************************
`define ACIS_C0_START        7
`define ACIS_C0_BUSY         6
`define ACIS_C0_ENABLE       5
`define ACIS_C0_FORMAT       4
`define ACIS_C0_CHAN_HI      3
`define ACIS_C0_CHAN_LO      0

// ****************************************************************
// field positions, control register 1 and mode register
// ****************************************************************
`define ACIS_C1_SRC_HI       7
`define ACIS_C1_SRC_LO       5
`define ACIS_C1_REF_HI       4
`define ACIS_C1_REF_LO       3
`define ACIS_C1_CLK_HI       2
`define ACIS_C1_CLK_LO       0
`define ACIS_MD_ACCUM        0
`define ACIS_MD_PINSEL_HI    7
`define ACIS_MD_PINSEL_LO    4

// ****************************************************************
// reset values and codes
// ****************************************************************
`define ACIS_RST_BYTE        8'h00
`define ACIS_REF_REGULATOR   2'h1
`define ACIS_SRC_AMP2        3'h1
`define ACIS_SRC_FILTER      3'h2
`define ACIS_SRC_AMP1        3'h3
`define ACIS_SRC_BATTERY     3'h4
`define ACIS_CHAN_COUNT      4'h4
`define ACIS_RESP_OKAY       2'h0
`define ACIS_RESP_SLVERR     2'h2

// ****************************************************************
// timing in converter clock periods, and the last accumulation count
// ****************************************************************
`define ACIS_SAMPLE_TICKS    4'h4
`define ACIS_CONV_TICKS      4'hC
`define ACIS_LAST_TICK       4'hF
`define ACIS_ACCUM_LAST      5'h0F

`endif

// ---- rtl/acis_pin_mux.v ----
// pin-shared override: a pin chosen as converter input drops its other roles
`timescale 1ns/1ps
module acis_pin_mux (
  // selection
  input  wire [3:0] pin_function_select_in,
  // requests from the port logic
  input  wire [3:0] port_out_en_in,
  input  wire [3:0] pull_high_en_in,
  // effective pin controls
  output wire [3:0] pin_out_en_out,
  output wire [3:0] pin_pull_high_out,
  output wire [3:0] pin_analog_out
);

  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_pin
      // direction setting is overridden, no input programming needed
      assign pin_out_en_out[i]    = port_out_en_in[i] & ~pin_function_select_in[i];
      assign pin_pull_high_out[i] = pull_high_en_in[i] & ~pin_function_select_in[i];
      assign pin_analog_out[i]    = pin_function_select_in[i];
    end
  endgenerate

endmodule // acis_pin_mux

// ---- rtl/acis_top.v ----
// converter control registers, conversion sequencer and input selection
`timescale 1ns/1ps
`include "acis_defs.vh"
module acis_top (
  // clock and reset
  input  wire        clk_sys_in,
  input  wire        nrst_in,
  // axi4-lite write address
  input  wire [7:0]  s_axi_awaddr_in,
  input  wire        s_axi_awvalid_in,
  output wire        s_axi_awready_out,
  // axi4-lite write data and response
  input  wire [31:0] s_axi_wdata_in,
  input  wire [3:0]  s_axi_wstrb_in,
  input  wire        s_axi_wvalid_in,
  output wire        s_axi_wready_out,
  output reg  [1:0]  s_axi_bresp_out,
  output reg         s_axi_bvalid_out,
  input  wire        s_axi_bready_in,
  // axi4-lite read
  input  wire [7:0]  s_axi_araddr_in,
  input  wire        s_axi_arvalid_in,
  output wire        s_axi_arready_out,
  output reg  [31:0] s_axi_rdata_out,
  output reg  [1:0]  s_axi_rresp_out,
  output reg         s_axi_rvalid_out,
  input  wire        s_axi_rready_in,
  // analog core
  input  wire [11:0] conv_data_in,
  output wire        conv_power_out,
  output wire        conv_clk_en_out,
  output wire        sample_phase_out,
  output wire        conv_phase_out,
  output wire        conv_busy_out,
  output reg         conv_done_out,
  // input and reference selection
  output wire [3:0]  channel_switch_out,
  output wire [3:0]  internal_source_out,
  output wire        ref_regulator_out,
  output wire        ref_pin_out,
  // pin-shared control
  input  wire [3:0]  port_out_en_in,
  input  wire [3:0]  pull_high_en_in,
  output wire [3:0]  pin_out_en_out,
  output wire [3:0]  pin_pull_high_out,
  output wire [3:0]  pin_analog_out
);

  // ****************************************************************
  // sequencer states
  // ****************************************************************
  localparam [2:0] ST_IDLE   = 3'b001;
  localparam [2:0] ST_SAMPLE = 3'b010;
  localparam [2:0] ST_CONV   = 3'b100;

  // ****************************************************************
  // address decode
  // ****************************************************************
  function addr_ok;
    input [7:0] addr;
    begin
      case (addr)
        `ACIS_ADDR_CTRL0,
        `ACIS_ADDR_CTRL1,
        `ACIS_ADDR_RES_LO,
        `ACIS_ADDR_RES_HI,
        `ACIS_ADDR_MODE:   addr_ok = 1'b1;
        default:           addr_ok = 1'b0;
      endcase
    end
  endfunction

  // ****************************************************************
  // declarations
  // ****************************************************************
  reg         aw_hold_r;
  reg  [7:0]  awaddr_r;
  reg         w_hold_r;
  reg  [7:0]  wdata_r;
  reg         wstrb_r;
  reg         start_r;
  reg         enable_r;
  reg         format_r;
  reg  [3:0]  chan_r;
  reg  [2:0]  src_r;
  reg  [1:0]  ref_r;
  reg  [2:0]  ckdiv_r;
  reg         accum_r;
  reg  [3:0]  pinsel_r;
  reg  [2:0]  state_r;
  reg  [3:0]  tick_cnt_r;
  reg  [4:0]  acc_cnt_r;
  reg  [15:0] acc_sum_r;
  reg  [7:0]  res_lo_r;
  reg  [7:0]  res_hi_r;
  reg  [7:0]  rd_byte;
  wire        wr_go;
  wire        wr_ctrl0;
  wire        launch;
  wire        abort;
  wire        busy;
  wire        tick;
  wire [15:0] sum_nxt;
  wire        src_external;

  // ****************************************************************
  // axi4-lite write path
  // ****************************************************************
  // address and data are taken in either order and held until both are in
  assign s_axi_awready_out = ~aw_hold_r & ~s_axi_bvalid_out;
  assign s_axi_wready_out  = ~w_hold_r & ~s_axi_bvalid_out;
  assign wr_go             = aw_hold_r & w_hold_r & ~s_axi_bvalid_out;
  assign wr_ctrl0          = wr_go & wstrb_r & (awaddr_r == `ACIS_ADDR_CTRL0);

  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      aw_hold_r        <= 1'b0;
      awaddr_r         <= 8'h00;
      w_hold_r         <= 1'b0;
      wdata_r          <= 8'h00;
      wstrb_r          <= 1'b0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= `ACIS_RESP_OKAY;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata_in[7:0];
        wstrb_r  <= s_axi_wstrb_in[0];
      end
      if (wr_go) begin
        aw_hold_r        <= 1'b0;
        w_hold_r         <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= addr_ok(awaddr_r) ? `ACIS_RESP_OKAY : `ACIS_RESP_SLVERR;
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // control registers
  // ****************************************************************
  // the busy bit has no storage here, so writes to it simply vanish
  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      start_r  <= 1'b0;
      enable_r <= 1'b0;
      format_r <= 1'b0;
      chan_r   <= 4'h0;
      src_r    <= 3'h0;
      ref_r    <= 2'h0;
      ckdiv_r  <= 3'h0;
      accum_r  <= 1'b0;
      pinsel_r <= 4'h0;
    end else if (wr_go && wstrb_r) begin
      case (awaddr_r)
        `ACIS_ADDR_CTRL0: begin
          start_r  <= wdata_r[`ACIS_C0_START];
          enable_r <= wdata_r[`ACIS_C0_ENABLE];
          format_r <= wdata_r[`ACIS_C0_FORMAT];
          chan_r   <= wdata_r[`ACIS_C0_CHAN_HI:`ACIS_C0_CHAN_LO];
        end
        `ACIS_ADDR_CTRL1: begin
          src_r   <= wdata_r[`ACIS_C1_SRC_HI:`ACIS_C1_SRC_LO];
          ref_r   <= wdata_r[`ACIS_C1_REF_HI:`ACIS_C1_REF_LO];
          ckdiv_r <= wdata_r[`ACIS_C1_CLK_HI:`ACIS_C1_CLK_LO];
        end
        `ACIS_ADDR_MODE: begin
          accum_r  <= wdata_r[`ACIS_MD_ACCUM];
          pinsel_r <= wdata_r[`ACIS_MD_PINSEL_HI:`ACIS_MD_PINSEL_LO];
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // conversion sequencer
  // ****************************************************************
  // launch on a high-then-low start write with the enable bit written high
  assign busy    = ~state_r[0];
  assign launch  = wr_ctrl0 & start_r & ~wdata_r[`ACIS_C0_START]
                 & wdata_r[`ACIS_C0_ENABLE] & ~busy;
  assign sum_nxt = acc_sum_r + {4'h0, conv_data_in};

  // a write that clears enable stops the run at that same edge, so busy never outlives power
  assign abort   = ~enable_r | (wr_ctrl0 & ~wdata_r[`ACIS_C0_ENABLE]);

  acis_clk_div u_clk_div (
    .clk_sys_in (clk_sys_in),
    .nrst_in    (nrst_in),
    .restart_in (launch),
    .div_sel_in (ckdiv_r),
    .tick_out   (tick)
  );

  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_r       <= ST_IDLE;
      tick_cnt_r    <= 4'h0;
      acc_cnt_r     <= 5'h00;
      acc_sum_r     <= 16'h0000;
      res_lo_r      <= `ACIS_RST_BYTE;
      res_hi_r      <= `ACIS_RST_BYTE;
      conv_done_out <= 1'b0;
    end else begin
      conv_done_out <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (launch) begin
            state_r    <= ST_SAMPLE;
            tick_cnt_r <= 4'h0;
            acc_cnt_r  <= 5'h00;
            acc_sum_r  <= 16'h0000;
          end
        end
        ST_SAMPLE: begin
          if (abort) begin
            state_r <= ST_IDLE;
          end else if (tick) begin
            tick_cnt_r <= tick_cnt_r + 4'h1;
            if (tick_cnt_r == (`ACIS_SAMPLE_TICKS - 4'h1)) begin
              state_r <= ST_CONV;
            end
          end
        end
        ST_CONV: begin
          if (abort) begin
            state_r <= ST_IDLE;
          end else if (tick) begin
            tick_cnt_r <= tick_cnt_r + 4'h1;
            if (tick_cnt_r == `ACIS_LAST_TICK) begin
              if (accum_r && (acc_cnt_r != `ACIS_ACCUM_LAST)) begin
                acc_cnt_r <= acc_cnt_r + 5'h01;
                acc_sum_r <= sum_nxt;
                state_r   <= ST_SAMPLE;
              end else begin
                state_r       <= ST_IDLE;
                conv_done_out <= 1'b1;
                if (accum_r) begin
                  res_hi_r <= sum_nxt[15:8];
                  res_lo_r <= sum_nxt[7:0];
                end else if (format_r) begin
                  res_hi_r <= {4'h0, conv_data_in[11:8]};
                  res_lo_r <= conv_data_in[7:0];
                end else begin
                  res_hi_r <= conv_data_in[11:4];
                  res_lo_r <= {conv_data_in[3:0], 4'h0};
                end
              end
            end
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // analog core and input selection
  // ****************************************************************
  // the enable bit powers the core; results are only written on completion
  assign conv_power_out   = enable_r;
  assign conv_clk_en_out  = tick & busy;
  assign sample_phase_out = state_r[1];
  assign conv_phase_out   = state_r[2];
  assign conv_busy_out    = busy;

  // codes 000 and 101..111 keep the external channel
  assign src_external = (src_r == 3'h0) | (src_r > `ACIS_SRC_BATTERY);

  // an internal source code (001..100) turns every channel switch off, so a pin and an internal signal never meet
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_chan
      localparam [3:0] CODE = g;
      assign channel_switch_out[g] = enable_r & src_external
                                   & (chan_r == CODE);
    end
  endgenerate

  assign internal_source_out[0] = enable_r & (src_r == `ACIS_SRC_AMP2);
  assign internal_source_out[1] = enable_r & (src_r == `ACIS_SRC_FILTER);
  assign internal_source_out[2] = enable_r & (src_r == `ACIS_SRC_AMP1);
  assign internal_source_out[3] = enable_r & (src_r == `ACIS_SRC_BATTERY);

  assign ref_regulator_out = (ref_r == `ACIS_REF_REGULATOR);
  assign ref_pin_out       = ~ref_regulator_out;

  acis_pin_mux u_pin_mux (
    .pin_function_select_in (pinsel_r),
    .port_out_en_in         (port_out_en_in),
    .pull_high_en_in        (pull_high_en_in),
    .pin_out_en_out         (pin_out_en_out),
    .pin_pull_high_out      (pin_pull_high_out),
    .pin_analog_out         (pin_analog_out)
  );

  // ****************************************************************
  // axi4-lite read path
  // ****************************************************************
  assign s_axi_arready_out = ~s_axi_rvalid_out;

  always @* begin
    case (s_axi_araddr_in)
      `ACIS_ADDR_CTRL0:  rd_byte = {start_r, busy, enable_r, format_r, chan_r};
      `ACIS_ADDR_CTRL1:  rd_byte = {src_r, ref_r, ckdiv_r};
      `ACIS_ADDR_RES_LO: rd_byte = res_lo_r;
      `ACIS_ADDR_RES_HI: rd_byte = res_hi_r;
      `ACIS_ADDR_MODE:   rd_byte = {pinsel_r, 3'h0, accum_r};
      default:           rd_byte = 8'h00;
    endcase
  end

  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out  <= 32'h00000000;
      s_axi_rresp_out  <= `ACIS_RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out  <= {24'h000000, rd_byte};
      s_axi_rresp_out  <= addr_ok(s_axi_araddr_in) ? `ACIS_RESP_OKAY : `ACIS_RESP_SLVERR;
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end

endmodule // acis_top

// ---- sim/acis_checker.sv ----
// concurrent checks on the converter control block ports
`timescale 1ns/1ps
module acis_checker (
  input wire       clk_sys_in,
  input wire       nrst_in,
  input wire       conv_power_out,
  input wire       conv_clk_en_out,
  input wire       sample_phase_out,
  input wire       conv_phase_out,
  input wire       conv_busy_out,
  input wire       conv_done_out,
  input wire [3:0] channel_switch_out,
  input wire [3:0] internal_source_out,
  input wire       ref_regulator_out,
  input wire       ref_pin_out,
  input wire [3:0] port_out_en_in,
  input wire [3:0] pull_high_en_in,
  input wire [3:0] pin_out_en_out,
  input wire [3:0] pin_pull_high_out,
  input wire [3:0] pin_analog_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  // ****
  // converter ticks since launch, kept through the done cycle
  // ****
  reg [8:0] tick_r;
  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in)
      tick_r <= 9'h000;
    else if (!conv_busy_out)
      tick_r <= 9'h000;
    else if (conv_clk_en_out)
      tick_r <= tick_r + 9'h001;
  end
  a_done_ends_busy: assert property (conv_done_out |-> !conv_busy_out && $past(conv_busy_out))
    else $error("done without busy falling");
  a_done_count: assert property (conv_done_out |-> tick_r == 9'h010 || tick_r == 9'h100)
    else $error("wrong tick count at done");
  a_done_pulse: assert property (conv_done_out |=> !conv_done_out)
    else $error("done longer than one cycle");
  a_sample_four: assert property ($rose(conv_phase_out) |-> tick_r[3:0] == 4'h4)
    else $error("sampling not four ticks");
  a_phase_busy: assert property ((sample_phase_out ^ conv_phase_out) == conv_busy_out)
    else $error("phase does not match busy");
  a_tick_busy: assert property (conv_clk_en_out |-> conv_busy_out)
    else $error("tick while idle");
  a_off_idle: assert property (!conv_power_out |-> !conv_busy_out && !conv_done_out)
    else $error("activity while disabled");
  a_ref_one: assert property (ref_pin_out != ref_regulator_out)
    else $error("reference selection not exclusive");
  a_pin_role: assert property (pin_pull_high_out == (pull_high_en_in & ~pin_analog_out) &&
    pin_out_en_out == (port_out_en_in & ~pin_analog_out))
    else $error("analog pin keeps other role");
  a_mux_onehot: assert property ($onehot0(channel_switch_out) && $onehot0(internal_source_out))
    else $error("input switches not one-hot");
endmodule // acis_checker

bind acis_top acis_checker acis_checker_i (
  .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .conv_power_out(conv_power_out),
  .conv_clk_en_out(conv_clk_en_out), .sample_phase_out(sample_phase_out),
  .conv_phase_out(conv_phase_out), .conv_busy_out(conv_busy_out),
  .conv_done_out(conv_done_out), .channel_switch_out(channel_switch_out),
  .internal_source_out(internal_source_out), .ref_regulator_out(ref_regulator_out),
  .ref_pin_out(ref_pin_out), .port_out_en_in(port_out_en_in),
  .pull_high_en_in(pull_high_en_in), .pin_out_en_out(pin_out_en_out),
  .pin_pull_high_out(pin_pull_high_out), .pin_analog_out(pin_analog_out)
);

// ---- sim/testbench.sv ----
// self-checking bench for the converter control block
`timescale 1ns/1ps
`include "acis_defs.vh"
module testbench;
  reg         clk = 1'b0;
  reg         nrst = 1'b0;
  reg  [7:0]  awaddr = 8'h00, araddr = 8'h00;
  reg  [31:0] wdata = 32'h0;
  reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  reg  [11:0] cdata = 12'h000;
  reg  [3:0]  poe = 4'h0, pul = 4'h0, es;
  wire        awready, wready, bvalid, arready, rvalid, cpow, busy, done, rreg;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [3:0]  chs, isrc, poeo, pulo, pan;
  reg  [33:0] rq[$];
  reg  [1:0]  bq[$];
  reg  [31:0] dq[$];
  reg  [31:0] seed, bcnt = 0, cyc = 0;
  reg  [15:0] le = 16'h0;
  reg  [7:0]  i;
  integer     n_fail = 0, total_checks = 0;

  acis_top acis_top_i (
    .clk_sys_in(clk), .nrst_in(nrst),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .conv_data_in(cdata),
    .conv_power_out(cpow), .conv_clk_en_out(), .sample_phase_out(), .conv_phase_out(),
    .conv_busy_out(busy), .conv_done_out(done), .channel_switch_out(chs),
    .internal_source_out(isrc), .ref_regulator_out(rreg), .ref_pin_out(),
    .port_out_en_in(poe), .pull_high_en_in(pul), .pin_out_en_out(poeo),
    .pin_pull_high_out(pulo), .pin_analog_out(pan)
  );

  initial begin
    forever #12.5 clk = ~clk;
  end

  // ****
  // shared tasks
  // ****
  function automatic [31:0] xs(input [31:0] v);
    reg [31:0] t;
    begin
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction

  task results;
    begin
      if (n_fail == 0 && total_checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask

  task chk(input [33:0] g, input [33:0] e);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("ERROR %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask

  // both channels go out together; each is dropped at the edge that takes it
  task wr(input [7:0] a, input [7:0] d, input [1:0] r);
    reg aw_p;
    reg w_p;
    begin
      @(posedge clk);
      bq.push_back(r);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      aw_p = 1'b1;
      w_p = 1'b1;
      while (aw_p || w_p) begin
        @(posedge clk);
        if (aw_p && awready) begin
          awvalid <= 1'b0;
          aw_p = 1'b0;
        end
        if (w_p && wready) begin
          wvalid <= 1'b0;
          w_p = 1'b0;
        end
      end
      do @(posedge clk); while (!bvalid);
      bready <= 1'b0;
    end
  endtask

  task rd(input [7:0] a, input [33:0] e);
    begin
      @(posedge clk);
      rq.push_back(e);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge clk); while (!rvalid);
      rready <= 1'b0;
    end
  endtask

  // one conversion; ab drops the enable in mid-run and expects old results
  task conv(input [2:0] d, input f, input acc, input [3:0] ch, input ab);
    reg [15:0] e;
    begin
      seed = xs(seed);
      cdata <= seed[11:0];
      e = (f && !acc) ? {4'h0, seed[11:0]} : {seed[11:0], 4'h0};
      wr(`ACIS_ADDR_MODE, {7'h0, acc}, 2'h0);
      wr(`ACIS_ADDR_CTRL1, {5'h0, d}, 2'h0);
      wr(`ACIS_ADDR_CTRL0, {3'h5, f, ch}, 2'h0);
      if (!ab)
        dq.push_back((acc ? 32'h100 : 32'h10) << d);
      wr(`ACIS_ADDR_CTRL0, {3'h1, f, ch}, 2'h0);
      rd(`ACIS_ADDR_CTRL0, {26'h0, 3'h3, f, ch});
      if (ab) begin
        wr(`ACIS_ADDR_CTRL0, {3'h0, f, ch}, 2'h0);
        chk({33'h0, cpow}, 34'h0);
        e = le;
      end else if (d == 3'h3) begin
        wr(`ACIS_ADDR_CTRL0, {3'h5, f, ch}, 2'h0);
        wr(`ACIS_ADDR_CTRL0, {3'h1, f, ch}, 2'h0);
      end
      do @(posedge clk); while (busy);
      le = e;
      rd(`ACIS_ADDR_RES_LO, {26'h0, e[7:0]});
      rd(`ACIS_ADDR_RES_HI, {26'h0, e[15:8]});
    end
  endtask

  // ****
  // result watcher and hang limit
  // ****
  always @(posedge clk) begin
    if (rvalid && rready)
      chk({rresp, rdata}, rq.pop_front());
    if (bvalid && bready)
      chk({32'h0, bresp}, {32'h0, bq.pop_front()});
    if (done && dq.size() == 0)
      chk(34'h0, 34'h1);
    else if (done)
      chk({2'h0, bcnt}, {2'h0, dq.pop_front()});
    bcnt = busy ? bcnt + 1 : 0;
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      results;
    end
  end

  initial begin
    seed = 32'h7dd1e21e;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    for (i = 0; i < 5; i = i + 1)
      rd(i << 2, 34'h0);
    rd(8'h14, {2'h2, 32'h0});
    wr(8'h14, 8'hFF, 2'h2);
    wr(`ACIS_ADDR_CTRL0, 8'h5F, 2'h0);
    rd(`ACIS_ADDR_CTRL0, 34'h1F);
    seed = xs(seed);
    wr(`ACIS_ADDR_CTRL1, seed[7:0], 2'h0);
    rd(`ACIS_ADDR_CTRL1, {26'h0, seed[7:0]});
    wr(`ACIS_ADDR_CTRL1, 8'h00, 2'h0);
    for (i = 0; i < 16; i = i + 1) begin
      wr(`ACIS_ADDR_CTRL0, 8'h20 | i, 2'h0);
      @(negedge clk);
      chk({30'h0, chs}, (i < 4) ? 34'h1 << i : 34'h0);
    end
    // channel code is left at 15, so no pin joins an internal source
    // the reference pin is never set up as an input here, so regulator code 01 is safe
    for (i = 0; i < 32; i = i + 1) begin
      wr(`ACIS_ADDR_CTRL1, {i[4:0], 3'h0}, 2'h0);
      es = (i[4:2] >= 3'h1 && i[4:2] <= 3'h4) ? 4'h1 << (i[4:2] - 3'h1) : 4'h0;
      @(negedge clk);
      chk({29'h0, isrc, rreg}, {29'h0, es, i[1:0] == 2'h1});
    end
    for (i = 0; i < 6; i = i + 1) begin
      seed = xs(seed);
      @(posedge clk);
      poe <= seed[3:0];
      pul <= seed[7:4];
      wr(`ACIS_ADDR_MODE, {seed[11:8], 4'h0}, 2'h0);
      @(negedge clk);
      chk({22'h0, pan, poeo, pulo},
          {22'h0, seed[11:8], seed[3:0] & ~seed[11:8], seed[7:4] & ~seed[11:8]});
    end
    for (i = 0; i < 4; i = i + 1)
      conv(i[2:0], i[0], 1'b0, i[3:0], 1'b0);
    conv(3'h7, 1'b0, 1'b0, 4'h3, 1'b0);
    conv(3'h0, 1'b1, 1'b1, 4'h2, 1'b0);
    conv(3'h3, 1'b1, 1'b0, 4'h1, 1'b1);
    results;
  end
endmodule // testbench
